// [common/pddr_pkg.sv]
`default_nettype none
// Shared constants and types of the phase delay and data ready block
package pddr_pkg;
   // Channel count and phase code geometry
   localparam int NUM_CH = 6;
   localparam int CODE_W = 12;
   localparam int CNT_W = 12;
   localparam int OSR_SEL_W = 3;
   // Log2 of the smallest oversampling ratio (32)
   localparam int OSR_MIN_LOG = 5;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_PHASE_LOW = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_PHASE_HIGH = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_STATUS_COMM = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_CONFIG = 4'hc;

   // Field positions in phase_reg_high and phase_reg_low
   localparam int POS_PAIR_A = 0;
   localparam int POS_PAIR_B = 12;
   localparam int POS_PAIR_C = 0;

   // Field positions in status_comm_register
   localparam int POS_LINK = 0;
   localparam int POS_FLAGS = 8;

   // Field positions in the configuration register
   localparam int POS_OSR = 0;
   localparam int POS_PRE = 4;
   localparam int POS_EXT = 6;
   localparam int POS_EN = 8;

   // Configuration carried as one bundle
   typedef struct packed {
      logic ext_clk;
      logic [1:0] prescale;
      logic [OSR_SEL_W-1:0] osr_sel;
      logic [NUM_CH-1:0] chan_en;
   } pddr_cfg_t;

   // Values after reset
   localparam logic [CODE_W-1:0] RST_PHASE_LOW = 12'h000;
   localparam logic [2*CODE_W-1:0] RST_PHASE_HIGH = 24'h000000;
   localparam logic RST_LINK = 1'b1;
   localparam logic [NUM_CH-1:0] RST_FLAGS = 6'h3f;
   localparam pddr_cfg_t RST_CFG = '{ext_clk: 1'b0, prescale: 2'h0, osr_sel: 3'h3, chan_en: 6'h3f};
endpackage : pddr_pkg
`default_nettype wire

// [verification/pddr_host_mon.sv]
`default_nettype none
// Host side: counts ready interrupts, stamps updates and restarts
module pddr_host_mon
   import pddr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic data_ready_pin_n_o,
   input wire logic [NUM_CH-1:0] chan_latch_o,
   input wire logic chan_restart_o,
   output var int pins_o,
   output var int rsts_o,
   output var int rst_t_o,
   output var int lat_t_o [NUM_CH],
   output var logic [NUM_CH-1:0] lat_v_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cyc; // Free running cycle stamp
   // Polled like an interrupt input, once per clock
   always @(posedge clock_i) begin
      if (rst_i) begin
         cyc <= 0;
         pins_o <= 0;
         rsts_o <= 0;
         rst_t_o <= 0;
         lat_v_o <= '0;
      end else begin
         cyc <= cyc + 1;
         if (!data_ready_pin_n_o) pins_o <= pins_o + 1;
         if (chan_restart_o) begin
            rsts_o <= rsts_o + 1;
            rst_t_o <= cyc;
         end
         for (int i = 0; i < NUM_CH; i++) if (chan_latch_o[i]) lat_t_o[i] <= cyc;
         if (chan_latch_o != '0) lat_v_o <= chan_latch_o;
      end
   end
endmodule : pddr_host_mon
`default_nettype wire

// [verification/pddr_top_chk.sv]
`default_nettype none
// Port checks of the phase delay and data ready block
module pddr_top_chk
   import pddr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic osc_enable_o,
   input wire logic crystal_pin_two_pulldown_o,
   input wire logic data_ready_pin_n_o,
   input wire logic [NUM_CH-1:0] chan_latch_o,
   input wire logic chan_restart_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, reset cancels every check
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   // Phase writes restart all channels, even with the same value
   a_phase_restart: assert property ((wr_i && (addr_i == OFF_PHASE_LOW || addr_i == OFF_PHASE_HIGH))
      |=> chan_restart_o) else $error("no restart after phase write");
   a_restart_cause: assert property (chan_restart_o |-> $past(wr_i)) else $error("restart without write");
   // Oscillator enable and pin two pull-down are exclusive
   a_osc_excl: assert property (osc_enable_o != crystal_pin_two_pulldown_o) else $error("oscillator controls clash");
   a_osc_follow: assert property ((wr_i && addr_i == OFF_CONFIG) |-> ##2
      (crystal_pin_two_pulldown_o == $past(wdata_i[POS_EXT], 2))) else $error("pull-down ignores clock select");
   // Pin pulse is one cycle and always carries a channel update
   a_pin_single: assert property (!data_ready_pin_n_o |=> data_ready_pin_n_o) else $error("pin pulse too long");
   a_pin_cause: assert property (!data_ready_pin_n_o |-> chan_latch_o != '0) else $error("pin pulse alone");
   a_latch_pin: assert property (chan_latch_o != '0 |-> !data_ready_pin_n_o) else $error("update without pin");
   // Reference channels are ready together, with no repeat within 8 cycles
   a_odd_sync: assert property (chan_latch_o[1] |-> (chan_latch_o[3] && chan_latch_o[5]))
      else $error("odd channels apart");
   a_latch_gap: assert property (chan_latch_o[1] |=> !chan_latch_o[1] [*8]) else $error("odd update too soon");
endmodule : pddr_top_chk

bind pddr_top pddr_top_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_enable_o(osc_enable_o), .crystal_pin_two_pulldown_o(crystal_pin_two_pulldown_o),
   .data_ready_pin_n_o(data_ready_pin_n_o), .chan_latch_o(chan_latch_o), .chan_restart_o(chan_restart_o));
`default_nettype wire

// [verification/tb_phase_delay_data_ready.sv]
`default_nettype none
// Bench: register port driver, two master clocks, host monitor
module tb_phase_delay_data_ready
   import pddr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, xtal_clk_i = 1'b0, ext_clk_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0, rdata_o, d;
   logic osc_enable_o, crystal_pin_two_pulldown_o, data_ready_pin_n_o, chan_restart_o;
   logic [NUM_CH-1:0] chan_latch_o, lat_v;
   int pins, rsts, rst_t, n_errors = 0, compares = 0, tcount = 0;
   int lat_t [NUM_CH];

   // System clock, crystal of 8 cycles, external clock of 12 cycles
   initial forever #4 clock_i = ~clock_i;
   initial begin
      #3;
      forever #32 xtal_clk_i = ~xtal_clk_i;
   end
   initial begin
      #5;
      forever #48 ext_clk_i = ~ext_clk_i;
   end

   pddr_top dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .xtal_clk_i(xtal_clk_i), .ext_clk_i(ext_clk_i), .osc_enable_o(osc_enable_o),
      .crystal_pin_two_pulldown_o(crystal_pin_two_pulldown_o), .data_ready_pin_n_o(data_ready_pin_n_o), .chan_latch_o(chan_latch_o),
      .chan_restart_o(chan_restart_o));
   pddr_host_mon mon (.clock_i(clock_i), .rst_i(rst_i), .data_ready_pin_n_o(data_ready_pin_n_o),
      .chan_latch_o(chan_latch_o), .chan_restart_o(chan_restart_o), .pins_o(pins), .rsts_o(rsts),
      .rst_t_o(rst_t), .lat_t_o(lat_t), .lat_v_o(lat_v));

   // Verdict and end of run
   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   // Hang guard
   always @(posedge clock_i) begin
      tcount <= tcount + 1;
      if (tcount == 20000) begin
         n_errors = n_errors + 1;
         results();
      end
   end

   task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // Single cycle register write and read
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd

   // Wait for an update of one channel, one more clock lets the monitor stamp it
   task automatic wait_lat(input int ch);
      int k;
      k = 0;
      #1;
      while (chan_latch_o[ch] !== 1'b1 && k < 5000) begin
         @(posedge clock_i);
         #1;
         k++;
      end
      @(posedge clock_i);
      #1;
      chk("update seen", 1, k < 5000);
   endtask : wait_lat

   // Phase code as signed periods for a ratio select
   function automatic int sx(input logic [11:0] c, input int sel);
      int w;
      int v;
      w = 5 + sel;
      v = int'(c) & ((1 << w) - 1);
      if (c[w-1]) v = v - (1 << w);
      return v;
   endfunction : sx

   task automatic t_reset;
      rd(OFF_STATUS_COMM);
      chk("status", 32'h00003f01, d);
      rd(OFF_CONFIG);
      chk("config", 32'h00003f03, d);
      rd(OFF_PHASE_HIGH);
      chk("phase high", 32'h0, d);
      rd(4'h2);
      chk("unmapped", 32'h0, d);
      chk("osc enable", 1, osc_enable_o);
      $display("reset test done");
   endtask : t_reset

   // Program one setup, then judge first ready, pulses per period and pair delays
   task automatic run(input int sel, pre, ext, input logic [11:0] a, b, c, input int link,
                      input logic [NUM_CH-1:0] en, input int refo, npin);
      int p;
      int oversampling_ratio;
      int t;
      p = (ext != 0 ? 12 : 8) << pre;
      oversampling_ratio = 32 << sel;
      wr(OFF_STATUS_COMM, 32'(link));
      wr(OFF_CONFIG, 32'({en, 1'b0, ext[0], pre[1:0], 1'b0, sel[2:0]}));
      wr(OFF_PHASE_HIGH, 32'({b, a}));
      wr(OFF_PHASE_LOW, 32'(c));
      wait_lat(1);
      t = lat_t[1] - rst_t;
      chk("first ready", 1, t >= (oversampling_ratio / 2 + refo - 1) * p && t <= (oversampling_ratio / 2 + refo + 1) * p);
      @(posedge clock_i);
      t = pins;
      repeat (oversampling_ratio * p) @(posedge clock_i);
      chk("pulses per period", npin, pins - t);
      repeat (oversampling_ratio * p / 2 - p / 2) @(posedge clock_i);
      #1;
      if (link != 0) chk("linked update", en, lat_v);
      else begin
         chk("pair a", sx(a, sel) * p, lat_t[0] - lat_t[1]);
         chk("pair b", sx(b, sel) * p, lat_t[2] - lat_t[3]);
         chk("pair c", sx(c, sel) * p, lat_t[4] - lat_t[5]);
      end
      chk("osc enable", ext == 0, osc_enable_o);
      chk("crystal_pin_two pull", ext != 0, crystal_pin_two_pulldown_o);
      $display("run done sel %0d pre %0d ext %0d link %0d", sel, pre, ext, link);
   endtask : run

   task automatic t_restart;
      int n;
      n = rsts;
      wr(OFF_PHASE_LOW, 32'h00000003);
      @(posedge clock_i);
      #1;
      chk("restart", n + 1, rsts);
      rd(OFF_PHASE_LOW);
      chk("phase low", 32'h00000003, d);
      $display("restart test done");
   endtask : t_restart

   // Ready flags: clear on read, read only, per channel then linked
   task automatic t_flags;
      wr(OFF_STATUS_COMM, 32'h0);
      wr(OFF_CONFIG, 32'h00003f00);
      wr(OFF_PHASE_HIGH, 32'h00008008);
      wr(OFF_PHASE_LOW, 32'h00000008);
      wait_lat(1);
      rd(OFF_STATUS_COMM);
      rd(OFF_STATUS_COMM);
      chk("flags cleared", 32'h00003f00, d);
      wr(OFF_STATUS_COMM, 32'h0);
      rd(OFF_STATUS_COMM);
      chk("flags read only", 32'h00003f00, d);
      wait_lat(0);
      rd(OFF_STATUS_COMM);
      chk("even flags", 32'h00002a00, d);
      wr(OFF_STATUS_COMM, 32'h00000001);
      wait_lat(1);
      rd(OFF_STATUS_COMM);
      chk("linked flags", 32'h00000001, d);
      $display("flags test done");
   endtask : t_flags

   initial begin
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      run(0, 0, 0, 12'h002, 12'hffd, 12'h00f, 0, 6'h3f, 0, 4);
      run(0, 1, 0, 12'hff0, 12'hfe2, 12'hfff, 0, 6'h3f, 0, 4);
      run(1, 0, 1, 12'h021, 12'h010, 12'h000, 0, 6'h3f, 0, 3);
      run(0, 0, 0, 12'h005, 12'hffe, 12'h003, 1, 6'h3e, 3, 1);
      t_restart();
      t_flags();
      results();
   end
endmodule : tb_phase_delay_data_ready
`default_nettype wire

// [verilog/pddr_chan_slot.sv]
`default_nettype none
// Per channel ready position: sign extension, half period shift, compare
module pddr_chan_slot
   import pddr_pkg::*;
(
   input wire logic [CODE_W-1:0] code_i,
   input wire logic is_ref_i,
   input wire logic [OSR_SEL_W-1:0] osr_sel_i,
   input wire logic [CNT_W-1:0] cnt_i,
   input wire logic tick_i,
   output logic [CNT_W-1:0] offset_o,
   output logic hit_o
);
   logic [CODE_W-1:0] ext_code; // Code sign extended from active sign bit
   logic [3:0] sign_pos; // Active sign bit position
   logic [CODE_W:0] half_osr; // Half the oversampling ratio
   logic [CODE_W:0] sum; // Shifted position

   // Decode position inside the output period
   always_comb begin
      sign_pos = 4'(OSR_MIN_LOG - 1) + 4'(osr_sel_i);
      for (int i = 0; i < CODE_W; i++) begin
         // Bits above the active sign bit are ignored
         ext_code[i] = (4'(i) > sign_pos) ? code_i[sign_pos] : code_i[i];
      end
      if (is_ref_i) begin
         ext_code = '0;
      end
      half_osr = 13'h1 << sign_pos;
      // Even channel lags for positive codes, leads for negative
      sum = half_osr + {ext_code[CODE_W-1], ext_code};
      // Sign extension bounds the sum to 0 .. OVERSAMPLING_RATIO-1
      offset_o = sum[CNT_W-1:0];
      hit_o = tick_i & (cnt_i == offset_o);
   end
endmodule : pddr_chan_slot
`default_nettype wire

// [verilog/pddr_clk_gen.sv]
`default_nettype none
// Derives the digital modulator clock enable from the selected master clock pin
module pddr_clk_gen
   import pddr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic xtal_clk_i,
   input wire logic ext_clk_i,
   input wire logic ext_sel_i,
   input wire logic [1:0] prescale_i,
   output logic digital_mod_clock_tick_o
);
   logic [1:0] xtal_sync_ff; // Two stage synchroniser, crystal clock
   logic [1:0] ext_sync_ff; // Two stage synchroniser, external clock
   logic mclk_prev_ff; // Previous selected level
   logic [2:0] pre_cnt_ff; // Prescaler counter
   logic [2:0] nxt_pre_cnt;
   logic mclk_lvl; // Selected synchronised master clock
   logic mclk_edge; // Rising edge of master clock
   logic [2:0] pre_mask; // Divide mask for 1, 2, 4, 8

   // Synchronisers only feed their own second stage
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         xtal_sync_ff <= 2'h0;
         ext_sync_ff <= 2'h0;
         mclk_prev_ff <= 1'b0;
         pre_cnt_ff <= 3'h0;
      end else begin
         xtal_sync_ff <= {xtal_sync_ff[0], xtal_clk_i};
         ext_sync_ff <= {ext_sync_ff[0], ext_clk_i};
         mclk_prev_ff <= mclk_lvl;
         pre_cnt_ff <= nxt_pre_cnt;
      end
   end

   // Source choice, edge detection and prescaling
   always_comb begin
      mclk_lvl = ext_sel_i ? ext_sync_ff[1] : xtal_sync_ff[1];
      mclk_edge = mclk_lvl & ~mclk_prev_ff;
      pre_mask = 3'(({1'b0, 3'h1} << prescale_i) - 4'h1);
      nxt_pre_cnt = pre_cnt_ff;
      digital_mod_clock_tick_o = 1'b0;
      if (mclk_edge) begin
         nxt_pre_cnt = pre_cnt_ff + 3'h1;
         // One tick per prescaled period sets the delay unit
         digital_mod_clock_tick_o = ((pre_cnt_ff & pre_mask) == pre_mask);
      end
   end
endmodule : pddr_clk_gen
`default_nettype wire

// [verilog/pddr_top.sv]
`default_nettype none
// What this block does
// - Even channel delayed by phase code periods
// - Delay unit follows prescaler and master clock
// - Unlinked: pair ready spacing equals programmed delay
// - Starts shifted by half the ratio
// - Delay limited to half ratio range
// - Sign bit position follows oversampling ratio
// - Any phase write restarts all channels
// - Unlinked: every enabled channel pulses pin
// - Linked default: only most lagging pulses
// - Linked: all enabled outputs latched together
// - Ready flags are read only
// - Flags reset high, drop on update
// - Status read sets all flags high
// - Linked: flags update with pin pulse
// - Unlinked: flags update per channel
// - Flag low selects crystal oscillator
// - Flag high bypasses oscillator, pulls down
// - Three 12-bit pair codes in registers
// - Positive lags even channel, negative leads
module pddr_top
   import pddr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic xtal_clk_i,
   input wire logic ext_clk_i,
   output logic osc_enable_o,
   output logic crystal_pin_two_pulldown_o,
   output logic data_ready_pin_n_o,
   output logic [NUM_CH-1:0] chan_latch_o,
   output logic chan_restart_o
);
   // Register state
   logic [CODE_W-1:0] phase_reg_low_ff; // Pair C code
   logic [2*CODE_W-1:0] phase_reg_high_ff; // Pair B and pair A codes
   logic ready_link_select_ff; // Linked data ready mode
   pddr_cfg_t cfg_ff; // Ratio, prescaler, clock source, enables
   logic [NUM_CH-1:0] chan_ready_flags_ff; // Low means ready
   logic [DATA_W-1:0] rdata_ff; // Read data, one cycle after strobe
   // Next values of the register group
   logic [CODE_W-1:0] nxt_phase_reg_low;
   logic [2*CODE_W-1:0] nxt_phase_reg_high;
   logic nxt_ready_link_select;
   pddr_cfg_t nxt_cfg;
   logic [NUM_CH-1:0] nxt_chan_ready_flags;
   logic [DATA_W-1:0] nxt_rdata;

   // Timing state
   logic [CNT_W-1:0] cnt_ff; // Position in output period
   logic dr_n_ff; // Data ready pin, active low
   logic [NUM_CH-1:0] latch_ff; // Output register update pulses
   logic restart_ff; // Restart pulse to converters
   logic osc_en_ff; // Oscillator enable pin
   logic crystal_pin_two_pd_ff; // Pull down of crystal pin two
   // Next values of the timing group
   logic [CNT_W-1:0] nxt_cnt;
   logic nxt_dr_n;
   logic [NUM_CH-1:0] nxt_latch;
   logic nxt_restart;
   logic nxt_osc_en; // Oscillator runs while the crystal is chosen
   logic nxt_crystal_pin_two_pd; // Pin two pulled down for an external clock

   // Combinational helpers
   logic digital_mod_clock_tick; // One cycle per modulator clock period
   logic restart; // Restart request this cycle
   logic [CNT_W-1:0] cnt_last; // OVERSAMPLING_RATIO minus one
   logic [NUM_CH-1:0] hit; // Channel ready position reached
   logic [CNT_W-1:0] offset [NUM_CH]; // Ready position per channel
   logic [CODE_W-1:0] code [NUM_CH]; // Raw code per channel
   logic [CNT_W-1:0] lag_offset; // Position of most lagging enabled channel
   logic linked_hit; // Most lagging channel ready
   logic [NUM_CH-1:0] upd; // Output registers updated this cycle

   // Modulator clock enable from the chosen master clock
   // One tick marks one digital_mod_clock period of the selected source
   pddr_clk_gen u_clk_gen (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .xtal_clk_i(xtal_clk_i),
      .ext_clk_i(ext_clk_i),
      .ext_sel_i(cfg_ff.ext_clk),
      .prescale_i(cfg_ff.prescale),
      .digital_mod_clock_tick_o(digital_mod_clock_tick)
   );

   // Codes per channel: pair A is channels 1/0, B 3/2, C 5/4
   always_comb begin
      code[0] = phase_reg_high_ff[POS_PAIR_A +: CODE_W];
      // Odd channels are the reference and carry no code
      code[1] = '0;
      code[2] = phase_reg_high_ff[POS_PAIR_B +: CODE_W];
      code[3] = '0;
      code[4] = phase_reg_low_ff[POS_PAIR_C +: CODE_W];
      code[5] = '0;
   end

   // One slot per channel; odd channels are the time reference
   // Each slot sign extends its code and compares it with the counter
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_slot
      pddr_chan_slot u_slot (
         .code_i(code[ch]),
         .is_ref_i(ch % 2 == 1),
         .osr_sel_i(cfg_ff.osr_sel),
         .cnt_i(cnt_ff),
         .tick_i(digital_mod_clock_tick),
         .offset_o(offset[ch]),
         .hit_o(hit[ch])
      );
   end

   // Register writes and reads
   always_comb begin
      nxt_phase_reg_low = phase_reg_low_ff;
      nxt_phase_reg_high = phase_reg_high_ff;
      nxt_ready_link_select = ready_link_select_ff;
      nxt_cfg = cfg_ff;
      // Read data are zero unless a read is made
      nxt_rdata = '0;
      restart = 1'b0;
      // Writes land at the edge that samples the strobe
      if (wr_i) begin
         case (addr_i)
            OFF_PHASE_LOW: begin
               // Pair C code; rewriting the same value still restarts
               nxt_phase_reg_low = wdata_i[CODE_W-1:0];
               restart = 1'b1;
            end
            OFF_PHASE_HIGH: begin
               // Pair A in the low half, pair B above it
               nxt_phase_reg_high = wdata_i[2*CODE_W-1:0];
               restart = 1'b1;
            end
            OFF_STATUS_COMM: begin
               // Only the mode bit is writable; flags ignore writes
               nxt_ready_link_select = wdata_i[POS_LINK];
            end
            OFF_CONFIG: begin
               nxt_cfg.osr_sel = wdata_i[POS_OSR +: OSR_SEL_W];
               nxt_cfg.prescale = wdata_i[POS_PRE +: 2];
               nxt_cfg.ext_clk = wdata_i[POS_EXT];
               nxt_cfg.chan_en = wdata_i[POS_EN +: NUM_CH];
               // A new ratio moves every ready position
               restart = 1'b1;
            end
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end
      // Read data stand for the one cycle after the strobe
      if (rd_i) begin
         case (addr_i)
            OFF_PHASE_LOW: nxt_rdata[CODE_W-1:0] = phase_reg_low_ff;
            OFF_PHASE_HIGH: nxt_rdata[2*CODE_W-1:0] = phase_reg_high_ff;
            OFF_STATUS_COMM: begin
               // Flags read 1 while a channel has no fresh result
               nxt_rdata[POS_LINK] = ready_link_select_ff;
               nxt_rdata[POS_FLAGS +: NUM_CH] = chan_ready_flags_ff;
            end
            OFF_CONFIG: begin
               nxt_rdata[POS_OSR +: OSR_SEL_W] = cfg_ff.osr_sel;
               nxt_rdata[POS_PRE +: 2] = cfg_ff.prescale;
               nxt_rdata[POS_EXT] = cfg_ff.ext_clk;
               nxt_rdata[POS_EN +: NUM_CH] = cfg_ff.chan_en;
            end
            default: nxt_rdata = '0; // Unmapped reads return zero
         endcase
      end
   end

   // Output period counter and ready pulses
   always_comb begin
      // Last count of the output period, OVERSAMPLING_RATIO minus one
      cnt_last = 12'(({1'b0, 12'h1} << (OSR_MIN_LOG + 32'(cfg_ff.osr_sel))) - 13'h1);
      // Most lagging enabled channel has the latest position
      lag_offset = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         // Disabled channels never set the lagging point
         if (cfg_ff.chan_en[i] && offset[i] > lag_offset) begin
            lag_offset = offset[i];
         end
      end
      // Linked mode fires once, at the latest enabled position
      linked_hit = digital_mod_clock_tick & (cnt_ff == lag_offset) & (|cfg_ff.chan_en);
      if (ready_link_select_ff) begin
         // Every enabled channel latches with the most lagging one
         upd = {NUM_CH{linked_hit}} & cfg_ff.chan_en;
      end else begin
         // Each enabled channel fires at its own position
         upd = hit & cfg_ff.chan_en;
      end
      // A restart zeroes the count so every start moves together
      nxt_cnt = cnt_ff;
      if (restart) begin
         nxt_cnt = '0;
      end else if (digital_mod_clock_tick) begin
         nxt_cnt = (cnt_ff == cnt_last) ? '0 : cnt_ff + 12'h1;
      end
      // Pin low for one cycle on any update, never during a restart
      nxt_dr_n = ~(|upd) | restart;
      nxt_latch = restart ? '0 : upd;
      // Converters see the restart one cycle after the write
      nxt_restart = restart;
   end

   // Ready flags: update beats the read that sets them back
   always_comb begin
      // Flags hold unless read or updated
      nxt_chan_ready_flags = chan_ready_flags_ff;
      // Reading the status register marks every channel not ready
      if (rd_i && addr_i == OFF_STATUS_COMM) begin
         nxt_chan_ready_flags = RST_FLAGS;
      end
      // An update in the same cycle as a read leaves the flag low
      if (!restart) begin
         nxt_chan_ready_flags = nxt_chan_ready_flags & ~upd;
      end
   end

   // Oscillator pin controls follow the clock source select
   always_comb begin
      // Crystal in use: keep the oscillator running
      nxt_osc_en = ~cfg_ff.ext_clk;
      // External clock: oscillator bypassed, pin two held low
      nxt_crystal_pin_two_pd = cfg_ff.ext_clk;
   end

   // Register file state: phase codes, mode bit, configuration, read data
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         // Power up defaults: linked mode, all channels on
         phase_reg_low_ff <= RST_PHASE_LOW;
         phase_reg_high_ff <= RST_PHASE_HIGH;
         ready_link_select_ff <= RST_LINK;
         cfg_ff <= RST_CFG;
         rdata_ff <= '0;
      end else begin
         // Write and read results land here
         phase_reg_low_ff <= nxt_phase_reg_low;
         phase_reg_high_ff <= nxt_phase_reg_high;
         ready_link_select_ff <= nxt_ready_link_select;
         cfg_ff <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   // Timing state: period counter and the pulses it launches
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         // Counter starts from the reset point, pin idles high
         cnt_ff <= '0;
         dr_n_ff <= 1'b1;
         latch_ff <= '0;
         restart_ff <= 1'b0;
      end else begin
         // The tick gates the count; pulses last one clock
         cnt_ff <= nxt_cnt;
         dr_n_ff <= nxt_dr_n;
         latch_ff <= nxt_latch;
         restart_ff <= nxt_restart;
      end
   end

   // Ready flag state
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         // Nothing is ready after reset
         chan_ready_flags_ff <= RST_FLAGS;
      end else begin
         chan_ready_flags_ff <= nxt_chan_ready_flags;
      end
   end

   // Oscillator pin state
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         // Default source is the crystal
         osc_en_ff <= 1'b1;
         crystal_pin_two_pd_ff <= 1'b0;
      end else begin
         osc_en_ff <= nxt_osc_en;
         crystal_pin_two_pd_ff <= nxt_crystal_pin_two_pd;
      end
   end

   // Outputs straight from flip-flops
   assign rdata_o = rdata_ff;
   // Pin is active low and idles high after reset
   assign data_ready_pin_n_o = dr_n_ff;
   assign chan_latch_o = latch_ff;
   assign chan_restart_o = restart_ff;
   assign osc_enable_o = osc_en_ff;
   assign crystal_pin_two_pulldown_o = crystal_pin_two_pd_ff;
endmodule : pddr_top
`default_nettype wire
